// ### rtl/pc_core_pkg.sv
/*
 * constants for the program counter, return stack and indirect addressing core.
 * assumes one clock and a synchronous active-low reset; the register map is word per register.
 */
package pc_core_pkg;
    localparam int PC_W = 13;
    localparam int PCL_W = 8;
    localparam int PCH_W = 5;
    localparam int JUMP_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int DADDR_W = 9;
    localparam int FILE_ADDR_W = 7;
    // data-file addresses of the core registers
    localparam logic [6:0] ADDR_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] ADDR_PCL = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_FSR = 7'h04;
    localparam logic [6:0] ADDR_PC_UPPER_HOLDING_REG = 7'h0A;
    localparam int IRP_BIT = 7;
    localparam logic [7:0] STATUS_RST = 8'h18;
    // interrupt entry point; the value is a plain default
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    // axi-lite map, byte addresses
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_PC = 8'h04;
    localparam logic [7:0] REG_PC_UPPER_HOLDING_REG = 8'h08;
    localparam logic [7:0] REG_FSR = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IND_ADDR = 8'h14;
    // command codes in the low bits of REG_CMD, operand in [23:8]
    localparam logic [3:0] CMD_INC = 4'h1;
    localparam logic [3:0] CMD_WR_PCL = 4'h2;
    localparam logic [3:0] CMD_CALL = 4'h3;
    localparam logic [3:0] CMD_JUMP = 4'h4;
    localparam logic [3:0] CMD_RETURN = 4'h5;
    localparam logic [3:0] CMD_INT = 4'h6;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### rtl/ret_stack_if.sv
/*
 * interface carrying push, pop and data between the core and its return stack.
 * assumes both ends share aclk.
 */
`timescale 1ns/1ps
interface ret_stack_if;
    import pc_core_pkg::*;
    logic push;
    logic pop;
    logic [PC_W-1:0] push_data;
    logic [PC_W-1:0] top_data;
    modport core (output push, output pop, output push_data, input top_data);
    modport stack (input push, input pop, input push_data, output top_data);
endinterface

// ### rtl/ret_stack.sv
/*
 * eight-entry circular return stack, no overflow or underflow indication.
 * assumes push and pop are never raised together.
 */
`timescale 1ns/1ps
module ret_stack
    import pc_core_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // core side
    ret_stack_if.stack s
);
    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_r <= '0;
        end else if (s.push) begin
            sp_r <= sp_r + 3'h1;
        end else if (s.pop) begin
            sp_r <= sp_r - 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (s.push) begin
            mem[sp_r] <= s.push_data;
        end
    end

    assign s.top_data = mem[sp_r - 3'h1];
endmodule

// ### rtl/pc_core.sv
/*
 * program counter, return stack control and indirect data addressing, AXI4-Lite controlled.
 * assumes a single 100 MHz clock and synchronous active-low reset; one command per write.
 */
// Functional notes
// - counter is 13 bits; low byte readable and writable.
// - upper counter bits have no direct write; they load from the holding register, the jump operand, the stack or the vector.
// - every reset clears the whole counter.
// - writing the low byte also loads bits 12:8 from holding bits 4:0.
// - jumps and calls take only holding bits 4:3 as top bits.
// - eight-entry 13-bit stack with hidden pointer.
// - calls push the counter plus one; interrupts push the current counter.
// - return pops into the counter.
// - push and pop leave the holding register unchanged.
// - stack is circular; ninth push overwrites the first.
// - no overflow or underflow flags exist.
// - indirect port accesses the location the pointer selects.
// - reading the port through itself returns zero.
// - indirect address is bank bit over the 8-bit pointer.
`timescale 1ns/1ps
module pc_core
    import pc_core_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // data memory address and program counter
    output logic [DADDR_W-1:0] ind_addr,
    output logic [PC_W-1:0] pc_out
);
    ret_stack_if stk ();

    ret_stack u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .s(stk.stack)
    );

    logic [PC_W-1:0] pc_r;
    logic [7:0] pc_upper_holding_reg_r;
    logic [7:0] fsr_r;
    logic [7:0] status_r;
    logic [DADDR_W-1:0] ind_addr_r;

    // write channel capture
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic [7:0] file_addr;
    logic [7:0] file_data;
    logic [3:0] cmd;
    logic [7:0] eff_addr;

    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign cmd = wdata_r[3:0];
    assign file_addr = wdata_r[15:8];
    assign file_data = wdata_r[23:16];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // command decode: an access to the indirect port resolves to the pointer target
    logic is_cmd;
    logic file_wr;
    always_comb begin
        is_cmd = wr_go && awaddr_r == REG_CMD && wstrb_r[0];
        eff_addr = file_addr;
        if (file_addr[6:0] == ADDR_INDIRECT_DATA_PORT) begin
            eff_addr = fsr_r;
        end
        file_wr = is_cmd && cmd == CMD_WR_PCL;
        if (file_wr && eff_addr[6:0] == ADDR_INDIRECT_DATA_PORT && file_addr[6:0] == ADDR_INDIRECT_DATA_PORT) begin
            file_wr = 1'b0;
        end
    end

    assign stk.push = is_cmd && (cmd == CMD_CALL || cmd == CMD_INT);
    assign stk.pop = is_cmd && cmd == CMD_RETURN;
    assign stk.push_data = (cmd == CMD_CALL) ? pc_r + 13'h0001 : pc_r;

    // program counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_r <= '0;
        end else if (is_cmd) begin
            unique case (cmd)
                CMD_INC: pc_r <= pc_r + 13'h0001;
                CMD_CALL, CMD_JUMP: pc_r <= {pc_upper_holding_reg_r[4:3], wdata_r[18:8]};
                CMD_RETURN: pc_r <= stk.top_data;
                CMD_INT: pc_r <= INT_VECTOR;
                default: begin
                    if (file_wr && eff_addr[6:0] == ADDR_PCL) begin
                        pc_r <= {pc_upper_holding_reg_r[4:0], file_data};
                    end
                end
            endcase
        end
    end

    // file registers; pushes and pops never touch the holding register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_upper_holding_reg_r <= 8'h00;
        end else if (file_wr && eff_addr[6:0] == ADDR_PC_UPPER_HOLDING_REG) begin
            pc_upper_holding_reg_r <= {3'b000, file_data[4:0]};
        end else if (wr_go && awaddr_r == REG_PC_UPPER_HOLDING_REG) begin
            pc_upper_holding_reg_r <= {3'b000, wdata_r[4:0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fsr_r <= 8'h00;
        end else if (file_wr && eff_addr[6:0] == ADDR_FSR) begin
            fsr_r <= file_data;
        end else if (wr_go && awaddr_r == REG_FSR) begin
            fsr_r <= wdata_r[7:0];
        end
    end

    // only the bank bits are writable; the low bits keep their reset value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= STATUS_RST;
        end else if (file_wr && eff_addr[6:0] == ADDR_STATUS) begin
            status_r <= {file_data[7:5], status_r[4:0]};
        end else if (wr_go && awaddr_r == REG_STATUS) begin
            status_r <= {wdata_r[7:5], status_r[4:0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ind_addr_r <= '0;
        end else begin
            ind_addr_r <= {status_r[IRP_BIT], fsr_r};
        end
    end

    assign ind_addr = ind_addr_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_out <= '0;
        end else begin
            pc_out <= pc_r;
        end
    end

    logic wr_ok;
    always_comb begin
        wr_ok = awaddr_r == REG_CMD || awaddr_r == REG_PC_UPPER_HOLDING_REG
            || awaddr_r == REG_FSR || awaddr_r == REG_STATUS;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_PC: s_axi_rdata <= {19'h00000, pc_r};
                REG_PC_UPPER_HOLDING_REG: s_axi_rdata <= {24'h000000, pc_upper_holding_reg_r};
                REG_FSR: s_axi_rdata <= {24'h000000, fsr_r};
                REG_STATUS: s_axi_rdata <= {24'h000000, status_r};
                REG_IND_ADDR: begin
                    // port through itself reads zero
                    if (fsr_r[6:0] == ADDR_INDIRECT_DATA_PORT) begin
                        s_axi_rdata <= 32'h0000_0000;
                    end else begin
                        s_axi_rdata <= {23'h000000, status_r[IRP_BIT], fsr_r};
                    end
                end
                REG_CMD: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ### tb/pc_core_monitor.sv
/* assertion checker on the pc_core ports.
   assumes a bind onto pc_core and one aclk domain. */
`timescale 1ns/1ps
module pc_core_monitor
    import pc_core_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // core outputs
    input wire logic [DADDR_W-1:0] ind_addr,
    input wire logic [PC_W-1:0] pc_out
);
    logic [7:0] aw_q;
    logic [7:0] ar_q;
    logic [31:0] w_q;
    // last accepted addresses and write word
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
        if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence done(logic [3:0] c);
        $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && aw_q == REG_CMD && w_q[3:0] == c;
    endsequence
    AST_PC_CLEAR: assert property ($rose(aresetn) |-> pc_out == '0)
        else $error("pc not clear after reset");
    AST_PC_READ: assert property (s_axi_rvalid && ar_q == REG_PC |->
        s_axi_rdata == {19'h0, pc_out}) else $error("pc read mismatch");
    AST_UPPER_SRC: assert property ($changed(pc_out[12:8]) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("upper pc moved alone");
    AST_PCL_LOAD: assert property (done(CMD_WR_PCL) ##0 w_q[14:8] == ADDR_PCL |=>
        pc_out[7:0] == w_q[23:16]) else $error("low byte not loaded");
    AST_JUMP_LOW: assert property (done(CMD_JUMP) |=> pc_out[10:0] == w_q[18:8])
        else $error("jump target wrong");
    AST_INT_VEC: assert property (done(CMD_INT) |=> pc_out == 13'h004)
        else $error("interrupt vector wrong");
    AST_PTR_ADDR: assert property ($rose(s_axi_bvalid) && aw_q == REG_FSR |=>
        ind_addr[7:0] == w_q[7:0]) else $error("pointer not on address");
    AST_BANK_BIT: assert property ($rose(s_axi_bvalid) && aw_q == REG_STATUS |=>
        ind_addr[8] == w_q[IRP_BIT]) else $error("bank bit not on address");
    AST_SELF_ZERO: assert property (s_axi_rvalid && ar_q == REG_IND_ADDR &&
        ind_addr[7:0] == 8'h00 |-> s_axi_rdata == 32'h0) else $error("self read not zero");
endmodule
bind pc_core pc_core_monitor pc_core_monitor_inst (.*);

// ### tb/axil_host_model.sv
/* axi-lite host standing in for the instruction decoder.
   assumes one aclk; tasks are called one at a time. */
`timescale 1ns/1ps
module axil_host_model (
    // clock
    input wire logic aclk,
    // write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // released payloads are inverted so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ### tb/pc_core_test.sv
/* self-checking bench for pc_core driven through an axi-lite host.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module pc_core_test
    import pc_core_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [DADDR_W-1:0] ind_addr;
    logic [PC_W-1:0] pc_out, e_pc, stk[8];
    logic [33:0] exp_q[$], got, ex;
    logic [4:0] hl;
    logic [2:0] sp = 3'h0;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    pc_core pc_core_inst (.*);
    axil_host_model axil_host_model_inst (.*);
    always #5 aclk = ~aclk;
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, 32'h0});
        axil_host_model_inst.wr(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        exp_q.push_back({r, d});
        axil_host_model_inst.rd(a);
    endtask
    // file write command through the data-file address map
    task automatic fw(input logic [6:0] fa, input logic [7:0] v);
        wr(REG_CMD, {8'h00, v, 1'b0, fa, 4'h0, CMD_WR_PCL});
    endtask
    // flow command with the expected counter and stack kept alongside
    task automatic step(input logic [3:0] c, input logic [10:0] t);
        wr(REG_CMD, {8'h00, 5'h0, t, 4'h0, c});
        if (c == CMD_CALL || c == CMD_INT) begin
            stk[sp] = (c == CMD_INT) ? e_pc : e_pc + 13'h1;
            sp++;
        end
        if (c == CMD_RETURN) begin
            sp--;
            e_pc = stk[sp];
        end
        else if (c == CMD_INC) e_pc = e_pc + 13'h1;
        else e_pc = (c == CMD_INT) ? 13'h004 : {hl[4:3], t};
        rd(REG_PC, 32'(e_pc));
    endtask
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            got = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
            ex = exp_q.pop_front();
            num_checks++;
            if (got !== ex) begin
                n_fail++;
                $display("wrong value axi response exp %h got %h", ex, got);
            end
        end
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        logic [7:0] d;
        e_pc = 13'h0;
        d = 8'($urandom(93418));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_PC, 32'h0);
        rd(REG_STATUS, 32'h18);
        rd(REG_FSR, 32'h0);
        hl = 5'($urandom);
        wr(REG_PC_UPPER_HOLDING_REG, 32'(hl));
        hl = hl + 5'h1;
        wr(REG_PC_UPPER_HOLDING_REG, 32'(hl));
        fw(ADDR_PCL, d);
        e_pc = {hl, d};
        rd(REG_PC, 32'(e_pc));
        step(CMD_JUMP, 11'($urandom));
        step(CMD_INC, 11'h0);
        for (int i = 0; i < 9; i++) step(CMD_CALL, 11'($urandom));
        for (int i = 0; i < 9; i++) step(CMD_RETURN, 11'h0);
        rd(REG_STATUS, 32'h18);
        step(CMD_INT, 11'h0);
        step(CMD_RETURN, 11'h0);
        rd(REG_PC_UPPER_HOLDING_REG, 32'(hl));
        d = 8'($urandom) | 8'h01;
        wr(REG_FSR, 32'(d));
        wr(REG_STATUS, 32'h80);
        rd(REG_IND_ADDR, {23'h0, 1'b1, d});
        wr(REG_FSR, 32'(ADDR_PC_UPPER_HOLDING_REG));
        hl = 5'($urandom);
        fw(ADDR_INDIRECT_DATA_PORT, {3'h0, hl});
        rd(REG_PC_UPPER_HOLDING_REG, 32'(hl));
        wr(REG_FSR, 32'h0);
        rd(REG_IND_ADDR, 32'h0);
        fw(ADDR_INDIRECT_DATA_PORT, 8'hA5);
        rd(REG_FSR, 32'h0);
        rd(REG_PC_UPPER_HOLDING_REG, 32'(hl));
        wr(8'h18, 32'h0, RESP_SLVERR);
        rd(8'h18, 32'h0, RESP_SLVERR);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_PC, 32'h0);
        stop_test();
    end
endmodule
